/* File: shared/srhier_defs.vh */
// Constants for the status reporting hierarchy: field positions, widths,
// reset values and access selectors of the documented register parts.
// Included by bare name from the rtl files; definitions only.
`ifndef SRHIER_DEFS_VH
`define SRHIER_DEFS_VH

// Widths
`define SRH_PART_W 16
`define SRH_SB_W 8

// Status byte bit positions
`define SRH_SB_ERRQ 2
`define SRH_SB_QUES 3
`define SRH_SB_MSG 4
`define SRH_SB_STDE 5
`define SRH_SB_MSTR 6
`define SRH_SB_OPER 7

// Always-zero top bit of a 16-bit part
`define SRH_PART_MSB 15

// Reset values
`define SRH_RST_PART 16'h0000
`define SRH_RST_BYTE 8'h00

// Part selectors of a five-part status register
`define SRH_SEL_COND 3'h0
`define SRH_SEL_RISE 3'h1
`define SRH_SEL_FALL 3'h2
`define SRH_SEL_EVNT 3'h3
`define SRH_SEL_ENAB 3'h4

// Register selectors for the part accesses
`define SRH_REG_OPER 2'h0
`define SRH_REG_QUES 2'h1
`define SRH_REG_STDE 2'h2

`endif

/* File: rtl/srhier_part_reg.v */
// One five-part 16-bit status register: condition, rising and falling
// edge filters, clear-on-read event latch, enable mask and sum bit.
// Assumes condition inputs are already in the clk_sys_i domain.
`timescale 1ns/10ps
`include "srhier_defs.vh"

module srhier_part_reg #(
    parameter W = 16
)(
    input wire clk_sys_i,
    input wire srst_i,
    input wire [W-1:0] cond_i,
    input wire [2:0] sel_i,
    input wire wr_i,
    input wire rd_i,
    input wire [W-1:0] wdata_i,
    output reg [W-1:0] rdata_o,
    output wire sum_o
);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    reg [W-1:0] cond_r;
    reg [W-1:0] rise_r;
    reg [W-1:0] fall_r;
    reg [W-1:0] evnt_r;
    reg [W-1:0] enab_r;
    wire [W-1:0] cond_m;
    wire [W-1:0] hit;
    wire [W-1:0] topmask;

    // Top bit forced low in every part
    assign topmask = {1'b0, {(W-1){1'b1}}};
    assign cond_m = cond_i & topmask;

    // Filtered transitions of the condition part
    assign hit = ((cond_m & ~cond_r) & rise_r)
        | ((~cond_m & cond_r) & fall_r);

    // Condition tracks inputs; writes never reach it
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            cond_r <= `SRH_RST_PART;
        else
            cond_r <= cond_m;
    end

    // Filter and enable parts, written only by software
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            rise_r <= `SRH_RST_PART;
            fall_r <= `SRH_RST_PART;
            enab_r <= `SRH_RST_PART;
        end
        else if (wr_i)
        begin
            if (sel_i == `SRH_SEL_RISE)
                rise_r <= wdata_i & topmask;
            if (sel_i == `SRH_SEL_FALL)
                fall_r <= wdata_i & topmask;
            if (sel_i == `SRH_SEL_ENAB)
                enab_r <= wdata_i & topmask;
        end
    end

    // Event latch: a transition in the read cycle beats the clear
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            evnt_r <= `SRH_RST_PART;
        else if (rd_i && sel_i == `SRH_SEL_EVNT)
            evnt_r <= hit;
        else
            evnt_r <= evnt_r | hit;
    end

    // Registered read data; reads only alter the event part
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            rdata_o <= `SRH_RST_PART;
        else if (rd_i)
        begin
            case (sel_i)
                `SRH_SEL_COND: rdata_o <= cond_r;
                `SRH_SEL_RISE: rdata_o <= rise_r;
                `SRH_SEL_FALL: rdata_o <= fall_r;
                `SRH_SEL_EVNT: rdata_o <= evnt_r;
                `SRH_SEL_ENAB: rdata_o <= enab_r;
                default: rdata_o <= `SRH_RST_PART;
            endcase
        end
    end

    // Sum bit feeds the next higher level
    assign sum_o = |(evnt_r & enab_r);

endmodule // srhier_part_reg

/* File: rtl/srhier_top.v */
// Status reporting hierarchy: operation, questionable and standard event
// registers summed into the status byte, service request and individual
// status flag.
// Assumes the command decoder runs on clk_sys_i; status pins may be async.
`timescale 1ns/10ps
`include "srhier_defs.vh"

module srhier_top #(
    parameter PW = 16,
    parameter BW = 8
)(
    input wire clk_sys_i,
    input wire srst_i,
    // Hardware condition inputs, asynchronous to clk_sys_i
    input wire [PW-1:0] oper_cond_i,
    input wire [PW-1:0] ques_cond_i,
    input wire [PW-1:0] stde_cond_i,
    input wire errq_not_empty_i,
    input wire errq_push_i,
    input wire msg_avail_i,
    // Part access from command decoder
    input wire [1:0] part_reg_i,
    input wire [2:0] part_sel_i,
    input wire part_wr_i,
    input wire part_rd_i,
    input wire [PW-1:0] part_wdata_i,
    output reg [PW-1:0] part_rdata_o,
    // Common commands and polls
    input wire sbyte_query_i,
    input wire serial_poll_i,
    input wire srm_wr_i,
    input wire srm_query_i,
    input wire ppoll_en_wr_i,
    input wire ppoll_en_query_i,
    input wire [BW-1:0] byte_wdata_i,
    output reg [BW-1:0] byte_rdata_o,
    // Bus side status
    output reg srq_o,
    output reg indiv_flag_o,
    output wire [BW-1:0] summary_status_byte_o
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    localparam SYW = 3 * PW + 2;
    reg [SYW-1:0] sync1_r;
    reg [SYW-1:0] sync2_r;
    reg push1_r;
    reg push2_r;
    reg push3_r;
    wire [PW-1:0] oper_c;
    wire [PW-1:0] ques_c;
    wire [PW-1:0] stde_c;
    wire errq_c;
    wire msg_c;
    wire push_p;

    // Two stages before any logic reads the pins
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sync1_r <= {SYW{1'b0}};
            sync2_r <= {SYW{1'b0}};
            push1_r <= 1'b0;
            push2_r <= 1'b0;
            push3_r <= 1'b0;
        end
        else
        begin
            sync1_r <= {oper_cond_i, ques_cond_i, stde_cond_i,
                errq_not_empty_i, msg_avail_i};
            sync2_r <= sync1_r;
            push1_r <= errq_push_i;
            push2_r <= push1_r;
            push3_r <= push2_r;
        end
    end

    assign oper_c = sync2_r[SYW-1 -: PW];
    assign ques_c = sync2_r[SYW-1-PW -: PW];
    assign stde_c = sync2_r[PW+1 -: PW];
    assign errq_c = sync2_r[1];
    assign msg_c = sync2_r[0];
    // Edge found on second and third stage only
    assign push_p = push2_r & ~push3_r;

    // ---------------------------------------------------------------
    // Lower status registers
    // ---------------------------------------------------------------
    wire [PW-1:0] oper_rd;
    wire [PW-1:0] ques_rd;
    wire [PW-1:0] stde_rd;
    wire oper_sum;
    wire ques_sum;
    wire stde_sum;
    wire [2:0] reg_wr;
    wire [2:0] reg_rd;

    // Steer the part access to one register
    assign reg_wr[0] = part_wr_i && part_reg_i == `SRH_REG_OPER;
    assign reg_wr[1] = part_wr_i && part_reg_i == `SRH_REG_QUES;
    assign reg_wr[2] = part_wr_i && part_reg_i == `SRH_REG_STDE;
    assign reg_rd[0] = part_rd_i && part_reg_i == `SRH_REG_OPER;
    assign reg_rd[1] = part_rd_i && part_reg_i == `SRH_REG_QUES;
    assign reg_rd[2] = part_rd_i && part_reg_i == `SRH_REG_STDE;

    srhier_part_reg #(
        .W(PW)
    ) u_oper (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .cond_i(oper_c),
        .sel_i(part_sel_i),
        .wr_i(reg_wr[0]),
        .rd_i(reg_rd[0]),
        .wdata_i(part_wdata_i),
        .rdata_o(oper_rd),
        .sum_o(oper_sum)
    );

    srhier_part_reg #(
        .W(PW)
    ) u_ques (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .cond_i(ques_c),
        .sel_i(part_sel_i),
        .wr_i(reg_wr[1]),
        .rd_i(reg_rd[1]),
        .wdata_i(part_wdata_i),
        .rdata_o(ques_rd),
        .sum_o(ques_sum)
    );

    // Standard event register, enable acts as its enable mask
    srhier_part_reg #(
        .W(PW)
    ) u_stde (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .cond_i(stde_c),
        .sel_i(part_sel_i),
        .wr_i(reg_wr[2]),
        .rd_i(reg_rd[2]),
        .wdata_i(part_wdata_i),
        .rdata_o(stde_rd),
        .sum_o(stde_sum)
    );

    // Return data of the register that was read last cycle
    reg [1:0] rd_reg_r;
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            rd_reg_r <= `SRH_REG_OPER;
        else if (part_rd_i)
            rd_reg_r <= part_reg_i;
    end

    always @*
    begin
        case (rd_reg_r)
            `SRH_REG_OPER: part_rdata_o = oper_rd;
            `SRH_REG_QUES: part_rdata_o = ques_rd;
            `SRH_REG_STDE: part_rdata_o = stde_rd;
            default: part_rdata_o = {PW{1'b0}};
        endcase
    end

    // ---------------------------------------------------------------
    // Status byte and masks
    // ---------------------------------------------------------------
    reg [BW-1:0] srm_r;
    reg [BW-1:0] ppoll_en_r;
    reg [BW-1:0] sbyte_r;
    wire [BW-1:0] sbyte_low;
    wire [BW-1:0] srm_eff;
    wire mstr_sum;
    wire [BW-1:0] sbyte_nxt;

    // Condition-like byte built from the lower sums and the queue and message bits
    assign sbyte_low = {oper_sum,
        1'b0,
        stde_sum,
        msg_c,
        ques_sum,
        errq_c,
        2'b00};

    // Mask bit 6 never counts toward the request
    assign srm_eff = srm_r & ~(8'h40);
    assign mstr_sum = |(sbyte_low & srm_eff);
    assign sbyte_nxt = sbyte_low | {1'b0, mstr_sum, 6'h00};

    // Request and poll enable masks
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            srm_r <= `SRH_RST_BYTE;
            ppoll_en_r <= `SRH_RST_BYTE;
        end
        else
        begin
            if (srm_wr_i)
                srm_r <= byte_wdata_i;
            if (ppoll_en_wr_i)
                ppoll_en_r <= byte_wdata_i;
        end
    end

    // Registered status byte; also the rise reference
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            sbyte_r <= `SRH_RST_BYTE;
        else
            sbyte_r <= sbyte_nxt;
    end

    assign summary_status_byte_o = sbyte_r;

    // ---------------------------------------------------------------
    // Service request and individual status flag
    // ---------------------------------------------------------------
    wire [BW-1:0] rise;
    wire req_ev;
    assign rise = sbyte_nxt & ~sbyte_r & srm_eff;
    // Each new queue entry requests again even when bit 2 stays set
    assign req_ev = (|rise) | (push_p & srm_eff[`SRH_SB_ERRQ]);

    // Request held until polled or no enabled status bit remains set
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            srq_o <= 1'b0;
        else if (req_ev)
            srq_o <= 1'b1;
        else if (serial_poll_i || !mstr_sum)
            srq_o <= 1'b0;
    end

    // Flag uses all bits including bit 6
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            indiv_flag_o <= 1'b0;
        else
            indiv_flag_o <= |(sbyte_nxt & ppoll_en_r);
    end

    // ---------------------------------------------------------------
    // Byte query answers
    // ---------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
            byte_rdata_o <= `SRH_RST_BYTE;
        else if (sbyte_query_i || serial_poll_i)
            byte_rdata_o <= sbyte_r;
        else if (srm_query_i)
            byte_rdata_o <= srm_r;
        else if (ppoll_en_query_i)
            byte_rdata_o <= ppoll_en_r;
    end

endmodule // srhier_top

/* File: verification/srhier_props.sv */
// Checker for the status byte, service request and flag of srhier_top.
// Assumes it is bound to srhier_top and sees only that module's ports.
`timescale 1ns/10ps
module srhier_props #(
    parameter PW = 16,
    parameter BW = 8
)(
    input wire clk_sys_i,
    input wire srst_i,
    input wire [PW-1:0] part_rdata_o,
    input wire sbyte_query_i,
    input wire serial_poll_i,
    input wire srm_wr_i,
    input wire srm_query_i,
    input wire ppoll_en_wr_i,
    input wire [BW-1:0] byte_wdata_i,
    input wire [BW-1:0] byte_rdata_o,
    input wire srq_o,
    input wire indiv_flag_o,
    input wire [BW-1:0] summary_status_byte_o
);
    reg [BW-1:0] srm_r;
    reg [BW-1:0] ppoll_en_r;
    reg [1:0] quiet_r;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // Shadow masks; quiet_r waits out the byte's settling after a change
    always @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            srm_r <= 8'h00;
            ppoll_en_r <= 8'h00;
            quiet_r <= 2'd0;
        end
        else
        begin
            if (srm_wr_i)
                srm_r <= byte_wdata_i;
            if (ppoll_en_wr_i)
                ppoll_en_r <= byte_wdata_i;
            if (srm_wr_i || ppoll_en_wr_i || !$stable(summary_status_byte_o))
                quiet_r <= 2'd0;
            else if (quiet_r != 2'd3)
                quiet_r <= quiet_r + 2'd1;
        end
    end
    sequence enabled_rise;
        |(summary_status_byte_o & ~$past(summary_status_byte_o)
          & srm_r & 8'hbf);
    endsequence
    sequence no_enabled_rise;
        !(|(summary_status_byte_o & ~$past(summary_status_byte_o)
          & srm_r & 8'hbf));
    endsequence
    msb_zero_a: assert property (part_rdata_o[PW-1] == 1'b0)
        else $error("part read data has top bit set");
    master_sum_a: assert property (quiet_r == 2'd3 |->
        summary_status_byte_o[6] == |(summary_status_byte_o & srm_r & 8'hbf))
        else $error("master summary bit wrong");
    flag_sum_a: assert property (quiet_r == 2'd3 |->
        indiv_flag_o == |(summary_status_byte_o & ppoll_en_r))
        else $error("individual status flag wrong");
    // A new queue entry may request with no byte edge while bit 2 is set
    srq_cause_a: assert property ($rose(srq_o)
        && !(summary_status_byte_o[2] && srm_r[2]) |-> enabled_rise)
        else $error("service request without enabled rise");
    srq_poll_a: assert property (serial_poll_i ##1 no_enabled_rise
        |-> !srq_o)
        else $error("service request held after poll");
    byte_read_a: assert property ((sbyte_query_i || serial_poll_i)
        |=> byte_rdata_o == $past(summary_status_byte_o))
        else $error("status byte read wrong");
    srm_read_a: assert property (srm_query_i && !sbyte_query_i
        && !serial_poll_i |=> byte_rdata_o == srm_r)
        else $error("request mask read wrong");
    reset_clear_a: assert property ($fell(srst_i) |-> !srq_o
        && !indiv_flag_o && summary_status_byte_o == 8'h00)
        else $error("outputs not cleared by reset");
endmodule // srhier_props
bind srhier_top srhier_props #(.PW(PW), .BW(BW)) u_srhier_props (
    .clk_sys_i, .srst_i, .part_rdata_o, .sbyte_query_i, .serial_poll_i,
    .srm_wr_i, .srm_query_i, .ppoll_en_wr_i, .byte_wdata_i, .byte_rdata_o,
    .srq_o, .indiv_flag_o, .summary_status_byte_o);

/* File: verification/srhier_ctrl_model.sv */
// Model of the remote bus controller: part accesses, queries and polls.
// Assumes one command per call; the bench calls its tasks by hierarchy.
`timescale 1ns/10ps
module srhier_ctrl_model (
    input wire clk_sys_i,
    input wire [15:0] part_rdata_i,
    input wire [7:0] byte_rdata_i,
    output reg [1:0] part_reg_o,
    output reg [2:0] part_sel_o,
    output reg part_wr_o,
    output reg part_rd_o,
    output reg [15:0] part_wdata_o,
    output reg [5:0] cmd_o,
    output reg [7:0] byte_wdata_o
);
    initial
    begin
        {part_reg_o, part_sel_o, part_wr_o, part_rd_o, cmd_o} = 0;
        part_wdata_o = 16'h0000;
        byte_wdata_o = 8'h00;
    end
    // One-cycle part access; data lines flip after use, not left valid
    task part_op(input [1:0] r, input [2:0] s, input wr, input [15:0] d,
                 output [15:0] q);
    begin
        @(posedge clk_sys_i);
        part_reg_o <= r;
        part_sel_o <= s;
        part_wr_o <= wr;
        part_rd_o <= !wr;
        part_wdata_o <= d;
        @(posedge clk_sys_i);
        part_wr_o <= 1'b0;
        part_rd_o <= 1'b0;
        part_wdata_o <= ~d;
        #1 q = part_rdata_i;
    end
    endtask
    // k: 0 byte query, 1 poll, 2 mask write, 3 mask query, 4/5 poll enable
    task byte_op(input [2:0] k, input [7:0] d, output [7:0] q);
    begin
        @(posedge clk_sys_i);
        cmd_o <= 6'h01 << k;
        byte_wdata_o <= d;
        @(posedge clk_sys_i);
        cmd_o <= 6'h00;
        byte_wdata_o <= ~d;
        #1 q = byte_rdata_i;
    end
    endtask
endmodule // srhier_ctrl_model

/* File: verification/tb_status_reporting_hierarchy.sv */
// Self-checking bench for srhier_top driven through the controller model.
// Assumes a 200 MHz clock and pin-to-byte latency of about four cycles.
`timescale 1ns/10ps
module tb_status_reporting_hierarchy;
    reg clk_sys_i = 0;
    reg srst_i = 1;
    reg [15:0] oper_c = 0, ques_c = 0, stde_c = 0;
    reg errq_ne = 0, errq_push = 0, msg_av = 0;
    wire [1:0] preg;
    wire [2:0] psel;
    wire pwr, prd, srq, flag;
    wire [15:0] pwd, prdat;
    wire [5:0] cmd;
    wire [7:0] bwd, brd, sbyte;
    integer bad_count = 0, checks_done = 0, cyc = 0, r;
    reg [15:0] q;
    reg [7:0] b;
    reg [7:0] sbit [0:2];
    srhier_top u_srhier_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .oper_cond_i(oper_c), .ques_cond_i(ques_c), .stde_cond_i(stde_c),
        .errq_not_empty_i(errq_ne), .errq_push_i(errq_push),
        .msg_avail_i(msg_av), .part_reg_i(preg), .part_sel_i(psel),
        .part_wr_i(pwr), .part_rd_i(prd), .part_wdata_i(pwd),
        .part_rdata_o(prdat), .sbyte_query_i(cmd[0]), .serial_poll_i(cmd[1]),
        .srm_wr_i(cmd[2]), .srm_query_i(cmd[3]), .ppoll_en_wr_i(cmd[4]),
        .ppoll_en_query_i(cmd[5]), .byte_wdata_i(bwd), .byte_rdata_o(brd),
        .srq_o(srq), .indiv_flag_o(flag), .summary_status_byte_o(sbyte));
    srhier_ctrl_model u_srhier_ctrl_model (.clk_sys_i(clk_sys_i),
        .part_rdata_i(prdat), .byte_rdata_i(brd), .part_reg_o(preg),
        .part_sel_o(psel), .part_wr_o(pwr), .part_rd_o(prd),
        .part_wdata_o(pwd), .cmd_o(cmd), .byte_wdata_o(bwd));
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard, generous against the two hundred or so cycles needed
    always @(posedge clk_sys_i)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end
    task chk(input [127:0] nm, input [15:0] seen, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task settle;
    begin
        repeat (6) @(posedge clk_sys_i);
    end
    endtask
    // Reset leaves the operation register's filter, event and enable parts and the request mask empty
    task t_reset;
    begin
        for (r = 1; r < 5; r = r + 1)
        begin
            u_srhier_ctrl_model.part_op(2'd0, r, 0, 0, q);
            chk("reset part", q, 16'h0000);
        end
        u_srhier_ctrl_model.byte_op(3, 0, b);
        chk("reset mask", b, 8'h00);
    end
    endtask
    // Edge filters pick transitions; event read returns then clears
    task t_edges;
    begin
        u_srhier_ctrl_model.part_op(0, 1, 1, 16'hffff, q);
        u_srhier_ctrl_model.part_op(0, 1, 0, 0, q);
        chk("rise filter", q, 16'h7fff);
        u_srhier_ctrl_model.part_op(0, 1, 1, 16'h0008, q);
        u_srhier_ctrl_model.part_op(0, 2, 1, 16'h0020, q);
        u_srhier_ctrl_model.part_op(0, 0, 1, 16'h1234, q);
        @(posedge clk_sys_i) oper_c <= 16'hc030;
        settle;
        u_srhier_ctrl_model.part_op(0, 0, 0, 0, q);
        chk("cond", q, 16'h4030);
        @(posedge clk_sys_i) oper_c <= 16'h8018;
        settle;
        u_srhier_ctrl_model.part_op(0, 3, 0, 0, q);
        chk("event", q, 16'h0028);
        u_srhier_ctrl_model.part_op(0, 3, 0, 0, q);
        chk("event clr", q, 16'h0000);
        @(posedge clk_sys_i) oper_c <= 16'h0000;
    end
    endtask
    // Sum bits of the three registers reach their status byte bits
    task t_sums;
    begin
        for (r = 0; r < 3; r = r + 1)
        begin
            u_srhier_ctrl_model.part_op(r, 1, 1, 16'h7fff, q);
            // One register at a time, so crossed condition pins show up
            @(posedge clk_sys_i)
                {oper_c, ques_c, stde_c} <= 48'h0000_0001 << (32 - 16 * r);
            settle;
            chk("sum masked", sbyte, 8'h00);
            u_srhier_ctrl_model.part_op(r, 4, 1, 16'h0001, q);
            settle;
            chk("sum set", sbyte, sbit[r]);
            u_srhier_ctrl_model.part_op(r, 3, 0, 0, q);
            settle;
            chk("sum clr", sbyte, 8'h00);
            @(posedge clk_sys_i) {oper_c, ques_c, stde_c} <= 0;
        end
    end
    endtask
    // Request, master summary, polls and the individual flag
    task t_srq;
    begin
        u_srhier_ctrl_model.byte_op(2, 8'h40, b);
        @(posedge clk_sys_i) msg_av <= 1'b1;
        settle;
        chk("mask bit6", {srq, sbyte[6]}, 2'b00);
        chk("msg bit", sbyte[4], 1'b1);
        u_srhier_ctrl_model.byte_op(2, 8'h14, b);
        u_srhier_ctrl_model.byte_op(3, 0, b);
        chk("mask rd", b, 8'h14);
        @(posedge clk_sys_i) msg_av <= 1'b0;
        settle;
        @(posedge clk_sys_i) msg_av <= 1'b1;
        settle;
        chk("srq", {srq, sbyte[6]}, 2'b11);
        u_srhier_ctrl_model.byte_op(1, 0, b);
        chk("poll", b, 8'h50);
        @(posedge clk_sys_i) {errq_ne, errq_push} <= 2'b11;
        settle;
        chk("errq", {srq, sbyte[2]}, 2'b11);
        // A second entry while bit 2 stays set must request again
        u_srhier_ctrl_model.byte_op(1, 0, b);
        chk("poll again", b, 8'h54);
        @(posedge clk_sys_i) errq_push <= 1'b0;
        settle;
        chk("polled", srq, 1'b0);
        @(posedge clk_sys_i) errq_push <= 1'b1;
        settle;
        chk("errq again", srq, 1'b1);
        u_srhier_ctrl_model.byte_op(4, 8'h40, b);
        settle;
        u_srhier_ctrl_model.byte_op(5, 0, b);
        chk("flag", {flag, b}, 9'h140);
        u_srhier_ctrl_model.byte_op(2, 0, b);
        settle;
        chk("flag off", flag, 1'b0);
        u_srhier_ctrl_model.byte_op(0, 0, b);
        chk("byte query", b, 8'h14);
    end
    endtask
    initial
    begin
        sbit[0] = 8'h80;
        sbit[1] = 8'h08;
        sbit[2] = 8'h20;
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_reset;
        t_edges;
        t_sums;
        t_srq;
        end_sim;
    end
endmodule // tb_status_reporting_hierarchy
